// ===== hw/muxed_bus_consts.svh
// constants and rule summary for the muxed bus host port
// Summary of operation
// RULE1: access happens only while chip select low
// RULE2: host holds chip select through strobes
// RULE3: address strobe without select still latches address
// RULE4: latch address on address strobe falling edge
// RULE5: write strobe low window writes register
// RULE6: read data driven only while read low
// RULE7: read strobe with select enables drivers
// RULE8: host sets address before strobe falls
// RULE9: host keeps write data stable late
// RULE10: drive 8 bits, release on read high
// RULE11: latched address holds until next strobe
`ifndef MUXED_BUS_CONSTS_SVH
`define MUXED_BUS_CONSTS_SVH
`define MBP_DATA_W 8
`define MBP_ADDR_RST 8'h00
`define MBP_SYNC_STAGES 2
`endif

// ===== hw/muxed_bus_pkg.sv
// types for the muxed bus host port
package muxed_bus_pkg;
  typedef logic [7:0] bus_byte_t;
  typedef enum logic [1:0] {ph_idle, ph_write, ph_read} bus_phase_t;
endpackage

// ===== hw/pin_sync.sv
// two flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_q
);
  logic [WIDTH-1:0] meta_q;

  // first stage read only by second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      pin_sync_q <= RST_VAL;
    end else begin
      meta_q <= pin_in;
      pin_sync_q <= meta_q;
    end
  end
endmodule

// ===== hw/muxed_bus_host_port.sv
// muxed address/data host port: address latch, read and write paths
`timescale 1ns/1ps
`include "muxed_bus_consts.svh"
module muxed_bus_host_port #(
  parameter int DATA_W = `MBP_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic addr_strobe,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire muxed_bus_pkg::bus_byte_t muxed_bus_lines_in,
  output muxed_bus_pkg::bus_byte_t muxed_bus_lines_out,
  output logic muxed_bus_lines_oe,
  output muxed_bus_pkg::bus_byte_t reg_addr,
  output muxed_bus_pkg::bus_byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire muxed_bus_pkg::bus_byte_t reg_rdata
);
  import muxed_bus_pkg::*;

  // pins cross two flops, so every answer lags its pin by about
  // three edges, and strobes shorter than one clock can be lost;
  // hosts must stretch their strobes to suit the clock
  localparam int NCTL = 4;
  // control pin order inside the synchronised group
  localparam int CS_BIT = 3;
  localparam int AS_BIT = 2;
  localparam int WR_BIT = 1;
  localparam int RD_BIT = 0;
  // pins at rest: select, write and read high, strobe low
  localparam logic [NCTL-1:0] CTL_IDLE = 4'hb;
  // which control pins are active low
  localparam logic [NCTL-1:0] CTL_ACT_LOW = 4'hb;

  logic [NCTL-1:0] ctl_sync_q;
  logic [DATA_W-1:0] data_sync_q;
  logic [NCTL-1:0] ctl_lvl;

  // decoded levels, active high
  logic cs_s;
  logic as_s;
  logic wr_s;
  logic rd_s;
  bus_byte_t bus_s;

  // edge history
  logic as_prev_q;
  logic wr_prev_q;
  logic as_fall;
  logic wr_end;

  // phase of the current cycle
  bus_phase_t phase_d;
  bus_phase_t phase_q;
  logic rd_now;

  // registered outputs
  bus_byte_t addr_q;
  bus_byte_t wdata_q;
  bus_byte_t rdata_q;
  logic wr_q;
  logic rd_q;
  logic oe_q;

  // high to low between two samples
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  // read needs select and no write; write needs select and no read
  function automatic bus_phase_t phase_of(input logic sel,
                                          input logic rd,
                                          input logic wr);
    bus_phase_t ph;
    ph = ph_idle;
    if (sel && rd && !wr) begin
      ph = ph_read;
    end else if (sel && wr && !rd) begin
      ph = ph_write;
    end
    return ph;
  endfunction

  // strobes reset to idle levels, so no false edge after reset
  pin_sync #(
    .WIDTH(NCTL),
    .RST_VAL(CTL_IDLE)
  ) u_ctl_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({cs_n, addr_strobe, wr_n, rd_n}),
    .pin_sync_q(ctl_sync_q)
  );

  // bus lines share the strobes' delay, so the latched byte matches
  pin_sync #(
    .WIDTH(DATA_W),
    .RST_VAL('0)
  ) u_data_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(muxed_bus_lines_in),
    .pin_sync_q(data_sync_q)
  );

  // polarity fold: every control level active high from here on
  generate
    for (genvar gi = 0; gi < NCTL; gi++) begin : g_pol
      assign ctl_lvl[gi] = ctl_sync_q[gi] ^ CTL_ACT_LOW[gi];
    end
  endgenerate

  assign cs_s = ctl_lvl[CS_BIT];
  assign as_s = ctl_lvl[AS_BIT];
  assign wr_s = ctl_lvl[WR_BIT];
  assign rd_s = ctl_lvl[RD_BIT];
  assign bus_s = data_sync_q;

  // this cycle's edges and phase
  assign as_fall = fell(as_prev_q, as_s);
  assign wr_end = fell(wr_prev_q, wr_s);
  assign phase_d = phase_of(cs_s, rd_s, wr_s);
  assign rd_now = (phase_d == ph_read);

  // address strobe history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      as_prev_q <= 1'b0;
    end else begin
      as_prev_q <= as_s;
    end
  end

  // write strobe history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_s;
    end
  end

  // address latch, independent of chip select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= `MBP_ADDR_RST;
    end else begin
      if (as_fall) begin // see RULE4 RULE3 RULE11
        addr_q <= bus_s;
      end
    end
  end

  // last byte seen while the write strobe is low with select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdata_q <= '0;
    end else begin
      if (wr_s && cs_s) begin // see RULE5 RULE1
        wdata_q <= bus_s;
      end
    end
  end

  // commit at the trailing edge of the write strobe, select still low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr_end && cs_s; // see RULE5 RULE3
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= ph_idle;
    end else begin
      phase_q <= phase_d;
    end
  end

  // drivers on only in a clean read phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rd_now; // see RULE7 RULE6 RULE10 RULE3
    end
  end

  // one pulse as a read phase opens
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_now && (phase_q != ph_read); // see RULE1
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      if (rd_now) begin // see RULE10
        rdata_q <= reg_rdata;
      end
    end
  end

  // every output straight from a register
  assign muxed_bus_lines_out = rdata_q;
  assign muxed_bus_lines_oe = oe_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_wr = wr_q;
  assign reg_rd = rd_q;
endmodule

// ===== test/muxed_bus_host_port_monitor.sv
// pin timing checker for the muxed bus host port
`timescale 1ns/1ps
module muxed_bus_port_checker (
  input wire logic sys_clk, rst, cs_n, addr_strobe, wr_n, rd_n,
  input wire logic muxed_bus_lines_oe, reg_wr, reg_rd,
  input wire muxed_bus_pkg::bus_byte_t muxed_bus_lines_in, reg_rdata,
  input wire muxed_bus_pkg::bus_byte_t muxed_bus_lines_out, reg_addr,
  input wire muxed_bus_pkg::bus_byte_t reg_wdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_oe_cause: assert property ($rose(muxed_bus_lines_oe) |->
    !$past(rd_n, 3) && !$past(cs_n, 3)) else $error("drive no read");
  a_rd_release: assert property ($rose(rd_n) |->
    ##[1:6] !muxed_bus_lines_oe) else $error("bus not released");
  a_off_no_drive: assert property (cs_n [*8] |->
    !muxed_bus_lines_oe) else $error("drive while deselected");
  a_off_no_write: assert property (cs_n [*8] |-> !reg_wr)
    else $error("write while deselected");
  a_addr_latch: assert property ($fell(addr_strobe) |-> ##3
    reg_addr == $past(muxed_bus_lines_in, 3)) else $error("bad address");
  a_addr_hold: assert property (!addr_strobe [*6] |->
    $stable(reg_addr)) else $error("address moved");
  a_wr_cause: assert property ($rose(reg_wr) |-> !$past(wr_n, 4) &&
    reg_wdata == $past(muxed_bus_lines_in, 4)) else $error("bad write");
  sequence s_drive_starts;
    $rose(muxed_bus_lines_oe);
  endsequence
  a_rd_start: assert property (reg_rd |-> s_drive_starts)
    else $error("read pulse without drive");
  a_out_follows: assert property (muxed_bus_lines_oe &&
    $past(muxed_bus_lines_oe) |-> muxed_bus_lines_out == $past(reg_rdata))
    else $error("bad read data");
endmodule
bind muxed_bus_host_port muxed_bus_port_checker u_chk (.*);

// ===== test/muxed_bus_host_model.sv
// processor side model driving the muxed bus pins
`timescale 1ns/1ps
module muxed_bus_host_model (
  input wire logic sys_clk,
  output logic cs_n, addr_strobe, wr_n, rd_n,
  output muxed_bus_pkg::bus_byte_t hb
);
  initial {cs_n, addr_strobe, wr_n, rd_n, hb} = 12'hb00;
  task automatic cyc(input logic s, w, input logic [7:0] a, d);
    @(posedge sys_clk);
    hb <= a;
    addr_strobe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    addr_strobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cs_n <= s;
    hb <= w ? d : ~a;
    wr_n <= !w;
    rd_n <= w;
    repeat (8) @(posedge sys_clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b1;
    hb <= ~hb;
  endtask
endmodule

// ===== test/test_muxed_bus_host_port.sv
// self-checking bench for the muxed bus host port
`timescale 1ns/1ps
module test_muxed_bus_host_port;
  import muxed_bus_pkg::*;
  logic sys_clk = 0, rst = 1, cs_n, addr_strobe, wr_n, rd_n;
  logic oe, wr_p, rd_p, s, w;
  bus_byte_t hb, bus_in, out, ra, rwd, rdata = 0, a, d, seen;
  int err_total = 0, check_count = 0, wcnt = 0, rcnt = 0, w0, r0;
  always #2 sys_clk = ~sys_clk;
  assign bus_in = oe ? out : hb;
  always @(posedge sys_clk) begin
    wcnt <= wcnt + int'(wr_p);
    rcnt <= rcnt + int'(rd_p);
    if (oe) seen <= out;
  end
  muxed_bus_host_model h (.sys_clk, .cs_n, .addr_strobe, .wr_n, .rd_n, .hb);
  muxed_bus_host_port i_dut (.sys_clk, .rst, .cs_n, .addr_strobe, .wr_n,
    .rd_n, .muxed_bus_lines_in(bus_in), .muxed_bus_lines_out(out),
    .muxed_bus_lines_oe(oe), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(wr_p),
    .reg_rd(rd_p), .reg_rdata(rdata));
  function automatic int n_exp(logic s, w, k);
    return int'(!s && w == k);
  endfunction
  task automatic chk(input string n, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #8000;
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(32'hcfb3));
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      {s, w, a, d} = i < 4 ? {2'(i), 16'($urandom)} : 18'($urandom);
      rdata <= 8'($urandom);
      w0 = wcnt;
      r0 = rcnt;
      h.cyc(s, w, a, d);
      repeat (4) @(posedge sys_clk);
      chk("addr", ra, a);
      chk("writes", wcnt - w0, n_exp(s, w, 1));
      chk("reads", rcnt - r0, n_exp(s, w, 0));
      if (n_exp(s, w, 1) == 1) chk("wdata", rwd, d);
      if (n_exp(s, w, 0) == 1) chk("rdata", seen, rdata);
    end
    final_report;
  end
endmodule
